// ---- hw/i2c_slave_pkg.sv ----
package i2c_slave_pkg;
    typedef struct packed {
        logic byteComplete;
        logic addrMatch;
        logic busBusy;
        logic txSelect;
        logic txAckLevel;
        logic readRequest;
        logic wakeEnable;
        logic rxAck;
    } control1_type;
    typedef struct packed {
        logic enable;
        logic flag;
        logic [5:0] period;
    } timeout_type;
    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } ahb_req_type;
    typedef enum logic [8:0] {
        ST_IDLE = 9'b0_0000_0001,
        ST_ADDR = 9'b0_0000_0010,
        ST_ACKA = 9'b0_0000_0100,
        ST_HOLD = 9'b0_0000_1000,
        ST_TX = 9'b0_0001_0000,
        ST_TXACK = 9'b0_0010_0000,
        ST_RX = 9'b0_0100_0000,
        ST_RXACK = 9'b0_1000_0000,
        ST_WAITSTOP = 9'b1_0000_0000
    } state_type;
endpackage

// ---- hw/i2c_slave_regs.svh ----
`ifndef I2C_SLAVE_REGS_SVH
`define I2C_SLAVE_REGS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define OFS_CONTROL0 8'h00
`define OFS_CONTROL1 8'h04
`define OFS_SLAVE_ADDR 8'h08
`define OFS_DATA_BUF 8'h0C
`define OFS_TIMEOUT 8'h10
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define POR_CONTROL0 8'h00
`define POR_CONTROL1 8'h81
`define POR_SLAVE_ADDR 7'h00
`define POR_TIMEOUT 8'h00
`define SUB_DIVIDE 5'h1F
`define BITS_PER_BYTE 4'h8
`define CONTROL0_ENABLE_BIT 0
`endif

// ---- hw/i2c_slave_transfer_timeout.sv ----
// Function
// [RULE_01] read bit one makes slave transmit
// [RULE_02] read bit zero makes slave receive
// [RULE_03] acknowledge own matching calling address
// [RULE_04] master stops after missing address acknowledge
// [RULE_05] transmit select follows read request flag
// [RULE_06] eight bit bytes, msb first
// [RULE_07] receiver drives ack level ninth clock
// [RULE_08] transmitter releases sda on no acknowledge
// [RULE_09] transmitter checks ack, else waits stop
// [RULE_10] bytes pass through serial data buffer
// [RULE_11] scl held until buffer write or read
// [RULE_12] timeout counts from match, scl fall clears
// [RULE_13] timeout when period passes without fall
// [RULE_14] stop condition halts timeout counting
// [RULE_15] overflow stops counter, flags, raises event
// [RULE_16] timeout resets engine and control one
// [RULE_17] software clears timeout flag by write
// [RULE_18] period is (select+1)*32 subclock cycles
// [RULE_19] seven address bits then read bit
// [RULE_20] address match sets flag and event
// [RULE_21] byte complete flag and event per byte
// [RULE_22] received ack flag reflects ninth clock
// [RULE_23] scl and sda synchronised before use
// [RULE_24] subclock synchronised before counting
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`include "i2c_slave_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_transfer_timeout (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register bus
    input wire i2c_slave_pkg::ahb_req_type ahbReq,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // i2c pins, open drain
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // slow clock and event
    input wire logic low_speed_subclock,
    output logic i2cEvent
);
    import i2c_slave_pkg::*;

    // ----------------------------------------
    // synchronisers and edge detection
    // ----------------------------------------
    logic [2:0] sclSync_reg, sdaSync_reg, subSync_reg;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclSync_reg <= 3'b111;
            sdaSync_reg <= 3'b111;
            subSync_reg <= 3'b000;
        end else begin
            sclSync_reg <= {sclSync_reg[1:0], sclIn}; // RULE_23
            sdaSync_reg <= {sdaSync_reg[1:0], sdaIn}; // RULE_23
            subSync_reg <= {subSync_reg[1:0], low_speed_subclock}; // RULE_24
        end
    end
    logic sclRise, sclFall, startDet, stopDet, subRise, sdaNow;
    assign sdaNow = sdaSync_reg[1];
    assign sclRise = sclSync_reg[1] & ~sclSync_reg[2];
    assign sclFall = ~sclSync_reg[1] & sclSync_reg[2];
    // start and stop need scl high in both samples so an scl edge is not misread
    assign startDet = sclSync_reg[1] & sclSync_reg[2] & ~sdaSync_reg[1] & sdaSync_reg[2];
    assign stopDet = sclSync_reg[1] & sclSync_reg[2] & sdaSync_reg[1] & ~sdaSync_reg[2];
    assign subRise = subSync_reg[1] & ~subSync_reg[2]; // RULE_24

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    state_type state_reg, state_next;
    control1_type ctrl1_reg, ctrl1_next;
    timeout_type to_reg, to_next;
    logic [7:0] ctrl0_reg, ctrl0_next;
    logic [6:0] slaveAddr_reg, slaveAddr_next;
    logic [7:0] dataBuf_reg, dataBuf_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] bitCnt_reg, bitCnt_next;
    logic [4:0] subDiv_reg, subDiv_next;
    logic [5:0] toCnt_reg, toCnt_next;
    logic toRun_reg, toRun_next;
    logic wrPend_reg, wrPend_next;
    logic [7:0] wrAddr_reg, wrAddr_next;
    logic [31:0] hrdata_next;
    logic sclOe_next, sdaOe_next, event_next;

    logic addrPhase, rdTake, toTick, toExpire;
    logic [7:0] rdVal, wdat;

    always_comb begin
        addrPhase = ahbReq.hsel & ahbReq.htrans[1] & ahbReq.hready;
        rdTake = addrPhase & ~ahbReq.hwrite;
        wdat = ahbReq.hwdata[7:0];
        state_next = state_reg;
        ctrl0_next = ctrl0_reg;
        ctrl1_next = ctrl1_reg;
        to_next = to_reg;
        slaveAddr_next = slaveAddr_reg;
        dataBuf_next = dataBuf_reg;
        shift_next = shift_reg;
        bitCnt_next = bitCnt_reg;
        sclOe_next = sclOe;
        sdaOe_next = sdaOe;
        event_next = 1'b0;
        wrPend_next = addrPhase & ahbReq.hwrite;
        wrAddr_next = ahbReq.haddr[7:0];
        // software register writes land in the data phase
        if (wrPend_reg) begin
            if (hit(wrAddr_reg, `OFS_CONTROL0)) ctrl0_next = wdat;
            if (hit(wrAddr_reg, `OFS_SLAVE_ADDR)) slaveAddr_next = wdat[7:1];
            if (hit(wrAddr_reg, `OFS_DATA_BUF)) dataBuf_next = wdat; // RULE_10
            if (hit(wrAddr_reg, `OFS_CONTROL1)) begin
                ctrl1_next.txSelect = wdat[4]; // RULE_05
                ctrl1_next.txAckLevel = wdat[3];
                ctrl1_next.wakeEnable = wdat[1];
            end
            if (hit(wrAddr_reg, `OFS_TIMEOUT)) begin
                to_next.enable = wdat[7];
                to_next.flag = to_reg.flag & wdat[6]; // RULE_17
                to_next.period = wdat[5:0];
            end
        end
        unique case (ahbReq.haddr[7:0])
            `OFS_CONTROL0: rdVal = ctrl0_reg;
            `OFS_CONTROL1: rdVal = ctrl1_reg;
            `OFS_SLAVE_ADDR: rdVal = {slaveAddr_reg, 1'b0};
            `OFS_DATA_BUF: rdVal = dataBuf_reg;
            `OFS_TIMEOUT: rdVal = to_reg;
            default: rdVal = 8'h00;
        endcase
        hrdata_next = rdTake ? {24'h00_0000, rdVal} : 32'h0000_0000;

        // protocol engine
        unique case (state_reg)
            ST_IDLE, ST_WAITSTOP: begin
                sdaOe_next = 1'b0; // RULE_09
                sclOe_next = 1'b0;
            end
            ST_ADDR: begin
                if (sclRise && bitCnt_reg < `BITS_PER_BYTE) begin
                    shift_next = {shift_reg[6:0], sdaNow}; // RULE_19
                    bitCnt_next = bitCnt_reg + 4'h1;
                end
                if (sclFall && bitCnt_reg == `BITS_PER_BYTE) begin
                    bitCnt_next = 4'h0;
                    if (shift_reg[7:1] == slaveAddr_reg) begin
                        ctrl1_next.addrMatch = 1'b1; // RULE_20
                        ctrl1_next.readRequest = shift_reg[0]; // RULE_19
                        ctrl1_next.txSelect = shift_reg[0]; // RULE_01 RULE_02 RULE_05
                        sdaOe_next = 1'b1; // RULE_03
                        event_next = 1'b1; // RULE_20
                        state_next = ST_ACKA;
                    end else begin
                        state_next = ST_WAITSTOP; // not us: stay off the bus
                    end
                end
            end
            ST_ACKA, ST_RXACK: begin
                if (sclFall) begin
                    sdaOe_next = 1'b0;
                    sclOe_next = 1'b1; // RULE_11
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // firmware must touch the buffer before the master may clock again
                if (wrPend_reg && hit(wrAddr_reg, `OFS_DATA_BUF) && ctrl1_reg.txSelect) begin
                    shift_next = wdat; // RULE_10
                    sdaOe_next = ~wdat[7]; // RULE_06
                    sclOe_next = 1'b0; // RULE_11
                    bitCnt_next = 4'h0;
                    ctrl1_next.byteComplete = 1'b0; // RULE_21
                    state_next = ST_TX; // RULE_01
                end else if (rdTake && hit(ahbReq.haddr[7:0], `OFS_DATA_BUF)
                             && !ctrl1_reg.txSelect) begin
                    sclOe_next = 1'b0; // RULE_11
                    bitCnt_next = 4'h0;
                    ctrl1_next.byteComplete = 1'b0; // RULE_21
                    state_next = ST_RX; // RULE_02
                end
            end
            ST_TX: begin
                if (sclFall) begin
                    bitCnt_next = bitCnt_reg + 4'h1;
                    shift_next = {shift_reg[6:0], 1'b0};
                    sdaOe_next = ~shift_reg[6]; // RULE_06
                    if (bitCnt_reg == `BITS_PER_BYTE - 4'h1) begin
                        sdaOe_next = 1'b0;
                        ctrl1_next.byteComplete = 1'b1; // RULE_21
                        event_next = 1'b1;
                        state_next = ST_TXACK;
                    end
                end
            end
            ST_TXACK: begin
                if (sclRise) ctrl1_next.rxAck = sdaNow; // RULE_22
                if (sclFall) begin
                    if (!ctrl1_reg.rxAck) begin
                        sclOe_next = 1'b1; // RULE_09 RULE_11
                        state_next = ST_HOLD;
                    end else begin
                        state_next = ST_WAITSTOP; // RULE_08
                    end
                end
            end
            ST_RX: begin
                if (sclRise && bitCnt_reg < `BITS_PER_BYTE) begin
                    shift_next = {shift_reg[6:0], sdaNow}; // RULE_06
                    bitCnt_next = bitCnt_reg + 4'h1;
                end
                if (sclFall && bitCnt_reg == `BITS_PER_BYTE) begin
                    dataBuf_next = shift_reg; // RULE_10
                    sdaOe_next = ~ctrl1_reg.txAckLevel; // RULE_07
                    ctrl1_next.byteComplete = 1'b1; // RULE_21
                    event_next = 1'b1;
                    state_next = ST_RXACK;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (startDet) begin
            ctrl1_next.busBusy = 1'b1;
            ctrl1_next.addrMatch = 1'b0;
            bitCnt_next = 4'h0;
            sdaOe_next = 1'b0;
            sclOe_next = 1'b0;
            state_next = ST_ADDR;
        end else if (stopDet) begin
            ctrl1_next.busBusy = 1'b0;
            sdaOe_next = 1'b0;
            sclOe_next = 1'b0;
            state_next = ST_IDLE;
        end

        // time-out: subclock / 32 ticks, counted while a matched transfer runs
        subDiv_next = subRise ? subDiv_reg + 5'h01 : subDiv_reg;
        toTick = subRise && subDiv_reg == `SUB_DIVIDE; // RULE_18
        toExpire = toRun_reg && toTick && toCnt_reg == to_reg.period; // RULE_13 RULE_18
        toRun_next = toRun_reg;
        toCnt_next = toCnt_reg;
        if (ctrl1_next.addrMatch && !ctrl1_reg.addrMatch && to_reg.enable) begin
            toRun_next = 1'b1; // RULE_12
            toCnt_next = 6'h00;
        end else if (stopDet || !to_reg.enable) begin
            toRun_next = 1'b0; // RULE_14
        end else if (sclFall) begin
            toCnt_next = 6'h00; // RULE_12
        end else if (toRun_reg && toTick) begin
            toCnt_next = toCnt_reg + 6'h01;
        end
        if (toExpire) begin
            toRun_next = 1'b0; // RULE_15
            toCnt_next = 6'h00;
            to_next.enable = 1'b0; // RULE_15
            to_next.flag = 1'b1; // RULE_15
            event_next = 1'b1; // RULE_15
            ctrl1_next = `POR_CONTROL1; // RULE_16
            sdaOe_next = 1'b0; // RULE_16
            sclOe_next = 1'b0;
            bitCnt_next = 4'h0;
            state_next = ST_IDLE; // RULE_16
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            ctrl0_reg <= `POR_CONTROL0;
            ctrl1_reg <= `POR_CONTROL1;
            to_reg <= `POR_TIMEOUT;
            slaveAddr_reg <= `POR_SLAVE_ADDR;
            dataBuf_reg <= 8'h00;
            shift_reg <= 8'h00;
            bitCnt_reg <= 4'h0;
            subDiv_reg <= 5'h00;
            toCnt_reg <= 6'h00;
            toRun_reg <= 1'b0;
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
            sclOe <= 1'b0;
            sdaOe <= 1'b0;
            i2cEvent <= 1'b0;
        end else begin
            state_reg <= state_next;
            ctrl0_reg <= ctrl0_next;
            ctrl1_reg <= ctrl1_next;
            to_reg <= to_next;
            slaveAddr_reg <= slaveAddr_next;
            dataBuf_reg <= dataBuf_next;
            shift_reg <= shift_next;
            bitCnt_reg <= bitCnt_next;
            subDiv_reg <= subDiv_next;
            toCnt_reg <= toCnt_next;
            toRun_reg <= toRun_next;
            wrPend_reg <= wrPend_next;
            wrAddr_reg <= wrAddr_next;
            hrdata <= hrdata_next;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
            sclOe <= sclOe_next;
            sdaOe <= sdaOe_next;
            i2cEvent <= event_next;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_match_ack: assert property ($rose(ctrl1_reg.addrMatch) |-> sdaOe && i2cEvent) // RULE_03
        else $error("no acknowledge after address match");
    a_read_bit: assert property ($rose(ctrl1_reg.addrMatch)
        |-> ctrl1_reg.readRequest == $past(shift_reg[0])
            && ctrl1_reg.txSelect == ctrl1_reg.readRequest) // RULE_05
        else $error("read bit or transmit select wrong after match");
    a_hold_scl: assert property (state_reg == ST_HOLD && $past(state_reg) == ST_HOLD
        |-> sclOe) // RULE_11
        else $error("scl not held while waiting on firmware");
    a_rx_ack_drive: assert property (state_reg == ST_RXACK && $past(state_reg) == ST_RX
        |-> sdaOe == !ctrl1_reg.txAckLevel && ctrl1_reg.byteComplete) // RULE_07
        else $error("receiver ack level wrong");
    a_tx_msb: assert property ($rose(state_reg == ST_TX)
        |-> sdaOe == !shift_reg[7]) // RULE_06
        else $error("transmit does not start with msb");
    a_tx_nack: assert property (state_reg == ST_TXACK && sclFall && ctrl1_reg.rxAck
        && !startDet && !stopDet && !toExpire |=> state_reg == ST_WAITSTOP ##1 !sdaOe) // RULE_08
        else $error("sda not released after missing acknowledge");
    a_stop_halt: assert property (stopDet |=> !toRun_reg) // RULE_14
        else $error("time-out still counting after stop");
    a_fall_clear: assert property (sclFall && toRun_reg && !stopDet && to_reg.enable
        |=> toCnt_reg == 6'h00) // RULE_12
        else $error("scl fall did not clear time-out count");
    a_timeout_act: assert property ($rose(to_reg.flag)
        |-> !to_reg.enable && state_reg == ST_IDLE && ctrl1_reg == `POR_CONTROL1
            && i2cEvent && !toRun_reg) // RULE_15
        else $error("time-out did not reset engine");
    a_period_len: assert property ($rose(to_reg.flag)
        |-> $past(toCnt_reg) == $past(to_reg.period)) // RULE_18
        else $error("time-out fired at wrong count");
endmodule
`default_nettype wire

// ---- tb/i2c_master.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----
// i2c bus master model, open drain drives
// ----
module i2c_master (
    // clock
    input wire logic clk,
    // wire levels
    input wire logic sclLine,
    input wire logic sdaLine,
    // drives, high = released
    output var logic sclDrv,
    output var logic sdaDrv
);
    // four quarters of 4 clk cycles (16 ns) each give a 64 ns link clock
    int quarter = 4;
    initial begin
        sclDrv = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
    endtask
    // slave may stretch scl; bounded so a stuck line cannot hang the run
    task automatic bit_cycle(input logic drive, output logic seen);
        int n;
        n = 0;
        sdaDrv <= drive;
        pause(quarter);
        sclDrv <= 1'b1;
        pause(1);
        while (sclLine !== 1'b1 && n < 50000) begin
            pause(1);
            n++;
        end
        // one cycle was spent seeing scl high, so the bit stays four quarters long
        pause(quarter - 1);
        seen = sdaLine;
        pause(quarter);
        sclDrv <= 1'b0;
        pause(quarter);
    endtask
    task automatic start_bit();
        sdaDrv <= 1'b1;
        sclDrv <= 1'b1;
        pause(quarter);
        sdaDrv <= 1'b0;
        pause(quarter);
        sclDrv <= 1'b0;
        pause(quarter);
    endtask
    task automatic stop_bit();
        sdaDrv <= 1'b0;
        pause(quarter);
        sclDrv <= 1'b1;
        pause(quarter);
        sdaDrv <= 1'b1;
        pause(quarter);
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], s);
        end
        bit_cycle(1'b1, ack);
    endtask
    task automatic get_byte(input logic ackBit, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            b[i] = s;
        end
        bit_cycle(ackBit, s);
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`include "i2c_slave_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
    import i2c_slave_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic low_speed_subclock = 1'b0;
    ahb_req_type busReq = '0;
    wire ahb_req_type busIn;
    logic [31:0] hrdata;
    logic hreadyout, hresp, sclOut, sclOe, sdaOut, sdaOe, i2cEvent;
    wire logic sclDrv, sdaDrv, sclLine, sdaLine;
    int badCount = 0;
    int checked = 0;
    int cycles = 0;
    int eventCount = 0;
    always #2 sys_clk = ~sys_clk;
    always #32 low_speed_subclock = ~low_speed_subclock;
    assign busIn = {busReq[$bits(ahb_req_type)-1:1], hreadyout};
    // released lines float high through pull-ups
    assign sclLine = sclDrv & ~(sclOe & ~sclOut);
    assign sdaLine = sdaDrv & ~(sdaOe & ~sdaOut);
    i2c_slave_transfer_timeout i2c_slave_transfer_timeout_i (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .ahbReq(busIn), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .low_speed_subclock(low_speed_subclock),
        .i2cEvent(i2cEvent));
    i2c_master i2c_master_i (.clk(sys_clk), .sclLine(sclLine), .sdaLine(sdaLine),
        .sclDrv(sclDrv), .sdaDrv(sdaDrv));
    always @(posedge sys_clk) begin
        if (i2cEvent === 1'b1) eventCount <= eventCount + 1;
    end
    // ----
    // helpers
    // ----
    task automatic finish_test();
        $display("checks %0d errors %0d", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            badCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge sys_clk);
        busReq.hsel <= 1'b1;
        busReq.haddr <= {24'h00_0000, a};
        busReq.htrans <= 2'b10;
        busReq.hwrite <= w;
        busReq.hsize <= 3'b010;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        busReq.hsel <= 1'b0;
        busReq.htrans <= 2'b00;
        busReq.hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        xfer(a, 1'b0, 32'h0000_0000, r);
        chk(r & m, e);
    endtask
    task automatic call_slave(input logic [6:0] a, input logic rw, output logic ack);
        i2c_master_i.start_bit();
        i2c_master_i.put_byte({a, rw}, ack);
    endtask
    // ----
    // scenarios
    // ----
    task automatic test_registers();
        rd(`OFS_CONTROL1, 32'h0000_00FF, 32'h0000_0081);
        chk({sclOut, sdaOut, hresp}, 32'h0000_0000);
        rd(`OFS_TIMEOUT, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(`OFS_SLAVE_ADDR, 32'h0000_005A);
        rd(`OFS_SLAVE_ADDR, 32'hFFFF_FFFF, 32'h0000_005A);
        wr(`OFS_CONTROL0, 32'h0000_0006);
        rd(`OFS_CONTROL0, 32'hFFFF_FFFF, 32'h0000_0006);
        wr(8'h14, 32'h0000_00FF);
        rd(8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(`OFS_TIMEOUT, 32'h0000_003F);
        rd(`OFS_TIMEOUT, 32'hFFFF_FFFF, 32'h0000_003F);
        wr(`OFS_TIMEOUT, 32'h0000_0000);
    endtask
    task automatic test_master_write();
        logic ack;
        logic [31:0] r;
        int ev;
        ev = eventCount;
        call_slave(7'h2D, 1'b0, ack);
        chk(ack, 0);
        chk(eventCount - ev, 1);
        rd(`OFS_CONTROL1, 32'h0000_0054, 32'h0000_0040);
        chk(sclOe, 1);
        xfer(`OFS_DATA_BUF, 1'b0, 32'h0000_0000, r);
        repeat (2) @(posedge sys_clk);
        chk(sclOe, 0);
        i2c_master_i.put_byte(8'hA5, ack);
        chk(ack, 0);
        rd(`OFS_CONTROL1, 32'h0000_0080, 32'h0000_0080);
        rd(`OFS_DATA_BUF, 32'h0000_00FF, 32'h0000_00A5);
        wr(`OFS_CONTROL1, 32'h0000_0008);
        i2c_master_i.put_byte(8'h96, ack);
        chk(ack, 1);
        rd(`OFS_DATA_BUF, 32'h0000_00FF, 32'h0000_0096);
        i2c_master_i.stop_bit();
        wr(`OFS_CONTROL1, 32'h0000_0000);
    endtask
    task automatic test_no_match();
        logic ack;
        int ev;
        ev = eventCount;
        call_slave(7'h2E, 1'b0, ack);
        chk(ack, 1);
        chk(eventCount - ev, 0);
        chk(sclOe, 0);
        i2c_master_i.stop_bit();
    endtask
    task automatic test_master_read();
        logic ack;
        logic [7:0] b;
        call_slave(7'h2D, 1'b1, ack);
        chk(ack, 0);
        rd(`OFS_CONTROL1, 32'h0000_0054, 32'h0000_0054);
        wr(`OFS_DATA_BUF, 32'h0000_003C);
        i2c_master_i.get_byte(1'b0, b);
        chk(b, 8'h3C);
        rd(`OFS_CONTROL1, 32'h0000_0081, 32'h0000_0080);
        wr(`OFS_DATA_BUF, 32'h0000_00C3);
        i2c_master_i.get_byte(1'b1, b);
        chk(b, 8'hC3);
        rd(`OFS_CONTROL1, 32'h0000_0001, 32'h0000_0001);
        chk(sdaOe, 0);
        chk(sclOe, 0);
        i2c_master_i.stop_bit();
    endtask
    task automatic test_timeout();
        logic ack;
        int n;
        wr(`OFS_TIMEOUT, 32'h0000_0081);
        call_slave(7'h2D, 1'b0, ack);
        n = 0;
        while (i2cEvent !== 1'b1 && n < 3000) begin
            @(posedge sys_clk);
            n++;
        end
        // period 1 is two ticks of 512 cycles; the free divider may cut one short
        chk(n >= 480 && n <= 1100, 1);
        rd(`OFS_TIMEOUT, 32'hFFFF_FFFF, 32'h0000_0041);
        rd(`OFS_CONTROL1, 32'hFFFF_FFFF, 32'h0000_0081);
        rd(`OFS_CONTROL0, 32'hFFFF_FFFF, 32'h0000_0006);
        rd(`OFS_SLAVE_ADDR, 32'hFFFF_FFFF, 32'h0000_005A);
        chk(sclOe, 0);
        wr(`OFS_TIMEOUT, 32'h0000_0001);
        rd(`OFS_TIMEOUT, 32'hFFFF_FFFF, 32'h0000_0001);
        i2c_master_i.stop_bit();
    endtask
    task automatic test_slow_transfer();
        logic ack;
        logic [31:0] r;
        i2c_master_i.quarter = 90;
        wr(`OFS_TIMEOUT, 32'h0000_0081);
        call_slave(7'h2D, 1'b0, ack);
        xfer(`OFS_DATA_BUF, 1'b0, 32'h0000_0000, r);
        i2c_master_i.put_byte(8'h11, ack);
        chk(ack, 0);
        // the slave stretches after the byte; read it so the stop can be seen
        xfer(`OFS_DATA_BUF, 1'b0, 32'h0000_0000, r);
        chk(r, 32'h0000_0011);
        i2c_master_i.stop_bit();
        i2c_master_i.quarter = 4;
        repeat (1500) @(posedge sys_clk);
        rd(`OFS_TIMEOUT, 32'hFFFF_FFFF, 32'h0000_0081);
        wr(`OFS_TIMEOUT, 32'h0000_0000);
    endtask
    // ----
    // main sequence and watchdog
    // ----
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            badCount++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        test_registers();
        test_master_write();
        test_no_match();
        test_master_read();
        test_slow_transfer();
        test_timeout();
        finish_test();
    end
endmodule
`default_nettype wire
